// ---- stp_gate_pkg.sv ----
// Contract
// - tail-tagged port is host only if it is the sole one; others STP-controlled
// - five states via three per-port controls
// - tx0 rx0 inhibit1: no traffic, no learning
// - tx0 rx0 inhibit0: learn, host traffic only
// - tx1 rx1 inhibit0: normal forwarding and learning
// - override static hit reaches host despite rx off
// - learning inhibit raises rapid table flush request
// - tail-tag override bit bypasses transmit permit when the lookup bit is clear
// - eight trees, 3-bit index selects state
package stp_gate_pkg;
   localparam int NUM_PORTS = 3;
   localparam int NUM_TREES = 8;
   localparam int PORT_W    = 2;
   localparam int TREE_W    = 3;
   // ------------------------------------------------------------
   // host-to-switch tail tag fields
   // ------------------------------------------------------------
   localparam int TT_LOOKUP_BIT   = 6;
   localparam int TT_OVERRIDE_BIT = 5;
   localparam int TT_PORT_MSB     = 2;
   // ------------------------------------------------------------
   // reset values: every tree discarding
   // ------------------------------------------------------------
   localparam logic [7:0] RST_TX_PERMIT = 8'h00;
   localparam logic [7:0] RST_RX_PERMIT = 8'h00;
   localparam logic [7:0] RST_LEARN_INH = 8'hFF;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_TREES-1:0] tx_permit;
      logic [NUM_TREES-1:0] rx_permit;
      logic [NUM_TREES-1:0] learn_inhibit;
   } stp_ctl_t;
   typedef struct packed {
      logic                 valid;
      logic [PORT_W-1:0]    port;
      logic [TREE_W-1:0]    tree;
      logic [NUM_PORTS-1:0] lookup_mask;
      logic                 static_override;
      logic [7:0]           tail_tag;
   } frame_req_t;
   typedef struct packed {
      logic                 valid;
      logic [NUM_PORTS-1:0] egress;
      logic                 learn;
   } decision_t;
endpackage

// ---- stp_port_state_gate.sv ----
`timescale 1ns/1ps
module stp_port_state_gate (
   input  wire logic                                 clock,
   input  wire logic                                 reset,
   input  wire logic [2:0]                           tail_tag_enable,
   input  wire stp_gate_pkg::stp_ctl_t [2:0]         port_ctl,
   input  wire logic [2:0]                           frame_start,
   input  wire logic [2:0]                           frame_end,
   input  wire stp_gate_pkg::frame_req_t             req,
   input  wire logic [2:0]                           flush_ack,
   output      stp_gate_pkg::decision_t              result,
   output      logic [2:0]                           flush_req,
   output      logic                                 host_valid,
   output      logic [1:0]                           host_port
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] tx_filter(
      input logic [2:0]                   m,
      input logic [2:0]                   hb,
      input stp_gate_pkg::stp_ctl_t [2:0] c,
      input logic [2:0]                   t);
      logic [2:0] ok;
      ok = hb;
      for (int p = 0; p < stp_gate_pkg::NUM_PORTS; p++) begin
         ok[p] = hb[p] | c[p].tx_permit[t];
      end
      return m & ok;
   endfunction

   function automatic logic [2:0] port_bit(input logic [1:0] p);
      logic [2:0] b;
      b = 3'h0;
      if (p < 2'h3) begin
         b[p] = 1'h1;
      end
      return b;
   endfunction

   // ------------------------------------------------------------
   // host port and per-frame control snapshot
   // ------------------------------------------------------------
   stp_gate_pkg::stp_ctl_t [2:0] eff;
   stp_gate_pkg::stp_ctl_t [2:0] next_eff;
   logic [2:0] busy;
   logic [2:0] next_busy;
   logic       next_host_valid;
   logic [1:0] next_host_port;
   logic [2:0] next_flush_req;
   logic [2:0] hb;

   always_comb begin
      next_host_valid = 1'h0;
      next_host_port  = 2'h0;
      case (tail_tag_enable)
         3'h1: begin
            next_host_valid = 1'h1;
            next_host_port  = 2'h0;
         end
         3'h2: begin
            next_host_valid = 1'h1;
            next_host_port  = 2'h1;
         end
         3'h4: begin
            next_host_valid = 1'h1;
            next_host_port  = 2'h2;
         end
         default: next_host_valid = 1'h0;
      endcase
      hb = host_valid ? port_bit(host_port) : 3'h0;
      for (int p = 0; p < stp_gate_pkg::NUM_PORTS; p++) begin
         next_busy[p] = (busy[p] | frame_start[p]) & ~frame_end[p];
         next_eff[p]  = busy[p] ? eff[p] : port_ctl[p];
         next_flush_req[p] = (flush_req[p] & ~flush_ack[p])
            | (~hb[p] & |(next_eff[p].learn_inhibit
                          & ~eff[p].learn_inhibit));
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         for (int p = 0; p < stp_gate_pkg::NUM_PORTS; p++) begin
            eff[p].tx_permit     <= stp_gate_pkg::RST_TX_PERMIT;
            eff[p].rx_permit     <= stp_gate_pkg::RST_RX_PERMIT;
            eff[p].learn_inhibit <= stp_gate_pkg::RST_LEARN_INH;
         end
         busy       <= 3'h0;
         flush_req  <= 3'h0;
         host_valid <= 1'h0;
         host_port  <= 2'h0;
      end else begin
         eff        <= next_eff;
         busy       <= next_busy;
         flush_req  <= next_flush_req;
         host_valid <= next_host_valid;
         host_port  <= next_host_port;
      end
   end

   // ------------------------------------------------------------
   // forwarding decision
   // ------------------------------------------------------------
   stp_gate_pkg::decision_t next_result;
   logic [2:0] src_bit;
   logic [2:0] raw;
   logic       rx_ok;

   always_comb begin
      src_bit = port_bit(req.port);
      raw     = req.tail_tag[stp_gate_pkg::TT_PORT_MSB:0] & ~hb;
      rx_ok   = eff[req.port[0+:2] % 2'h3].rx_permit[req.tree];
      next_result.valid  = req.valid;
      next_result.egress = 3'h0;
      next_result.learn  = 1'h0;
      if (!req.valid || src_bit == 3'h0) begin
         next_result.egress = 3'h0;
      end else if ((src_bit & hb) != 3'h0) begin
         next_result.learn = 1'h1;
         if (req.tail_tag[stp_gate_pkg::TT_LOOKUP_BIT]) begin
            next_result.egress = tx_filter(req.lookup_mask & ~hb, hb,
                                           eff, req.tree);
         end else if (req.tail_tag[stp_gate_pkg::TT_OVERRIDE_BIT]) begin
            next_result.egress = raw;
         end else begin
            next_result.egress = tx_filter(raw, hb, eff, req.tree);
         end
      end else begin
         next_result.learn =
            ~eff[req.port].learn_inhibit[req.tree];
         if (rx_ok) begin
            next_result.egress =
               (tx_filter(req.lookup_mask, hb, eff, req.tree)
                | (req.static_override ? hb : 3'h0)) & ~src_bit;
         end else begin
            next_result.egress = req.static_override ? hb : 3'h0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         result <= '0;
      end else begin
         result <= next_result;
      end
   end

   // ------------------------------------------------------------
   // expected user forwarding for the checks
   // ------------------------------------------------------------
   logic [2:0] tx_now;
   logic [2:0] fwd_expect;

   always_comb begin
      for (int p = 0; p < stp_gate_pkg::NUM_PORTS; p++) begin
         tx_now[p] = eff[p].tx_permit[req.tree] | hb[p];
      end
      fwd_expect = req.lookup_mask & tx_now & ~src_bit;
      if (req.static_override) begin
         fwd_expect = fwd_expect | hb;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   logic from_user;
   assign from_user = req.valid && src_bit != 3'h0 && (src_bit & hb) == 3'h0;

   host_port_one_a: assert property (
      $countones(tail_tag_enable) == 1 ##1 $stable(tail_tag_enable)
      |-> host_valid && port_bit(host_port) == tail_tag_enable)
      else $error("host port not the tail-tagged port");
   host_port_none_a: assert property (
      $countones(tail_tag_enable) != 1 |=> !host_valid)
      else $error("host port valid without single tail tag");
   discard_state_a: assert property (
      from_user && !eff[req.port].rx_permit[req.tree]
      && eff[req.port].learn_inhibit[req.tree] && !req.static_override
      |=> result.valid && result.egress == 3'h0 && !result.learn)
      else $error("discarding port passed traffic or learned");
   learning_state_a: assert property (
      from_user && !eff[req.port].rx_permit[req.tree]
      && !eff[req.port].learn_inhibit[req.tree]
      |=> result.learn && (result.egress & ~$past(hb)) == 3'h0)
      else $error("learning port passed user traffic");
   forward_state_a: assert property (
      from_user && eff[req.port].rx_permit[req.tree]
      && !eff[req.port].learn_inhibit[req.tree]
      |=> result.learn && result.egress == $past(fwd_expect))
      else $error("forwarding port decision wrong");
   override_host_a: assert property (
      from_user && req.static_override
      |=> (result.egress & $past(hb)) == $past(hb))
      else $error("override frame not delivered to host");
   flush_raise_a: assert property (
      !busy[0] && !hb[0] && !eff[0].learn_inhibit[0]
      && port_ctl[0].learn_inhibit[0] |=> flush_req[0])
      else $error("flush not requested on learning inhibit");
   flush_hold_a: assert property (
      flush_req[1] && !flush_ack[1] |=> flush_req[1])
      else $error("flush request dropped before ack");
   tag_override_a: assert property (
      req.valid && (src_bit & hb) != 3'h0
      && !req.tail_tag[stp_gate_pkg::TT_LOOKUP_BIT]
      && req.tail_tag[stp_gate_pkg::TT_OVERRIDE_BIT]
      |=> result.egress == $past(raw))
      else $error("override tail tag did not bypass blocking");
   frame_hold_a: assert property (
      busy[0] && !frame_end[0] |=> $stable(eff[0]))
      else $error("controls changed inside a frame");
   snapshot_take_a: assert property (
      frame_start[0] && !busy[0] |=> eff[0] == $past(port_ctl[0]))
      else $error("frame did not start with current controls");
   answer_next_a: assert property (
      req.valid |=> result.valid)
      else $error("decision not answered next cycle");
   answer_once_a: assert property (
      !req.valid |=> !result.valid)
      else $error("decision valid without a request");
   tree_select_a: assert property (
      from_user && !eff[req.port].rx_permit[req.tree]
      && !req.static_override |=> result.egress == 3'h0)
      else $error("tree index ignored");

   forward_c: cover property (from_user && rx_ok ##1 result.egress != 3'h0);
   override_c: cover property (from_user && !rx_ok && req.static_override);
   flush_c: cover property (flush_req[0] ##1 flush_ack[0]);
   frame_c: cover property (frame_start[0] ##1 busy[0]);
endmodule // stp_port_state_gate

// ---- host_proc_model.sv ----
`timescale 1ns/1ps
module host_proc_model (
   input  wire stp_gate_pkg::stp_ctl_t [2:0] ctl,
   input  wire logic [2:0]                   tree,
   input  wire logic [7:0]                   sel,
   input  wire logic [1:0]                   from_port,
   output      logic [7:0]                   tail_tag,
   output      logic                         keep
);
   logic [2:0] open_dst;
   always_comb begin
      keep = 1'h0;
      for (int d = 0; d < 3; d++) begin
         open_dst[d] = ~ctl[d].learn_inhibit[tree];
      end
      tail_tag = {1'h0, sel[6], sel[5], 2'h0, sel[2:0] & open_dst & 3'h3};
      if (from_port < 2'h3) begin
         keep = ~(ctl[from_port].learn_inhibit[tree]
            & ~ctl[from_port].rx_permit[tree]);
      end
   end
endmodule // host_proc_model

// ---- tb_stp_port_state_gate.sv ----
`timescale 1ns/1ps
module tb_stp_port_state_gate;
   logic                         clock = 1'h0;
   logic                         reset = 1'h1;
   logic [2:0]                   tail_tag_enable = 3'h4;
   stp_gate_pkg::stp_ctl_t [2:0] port_ctl = '0;
   logic [2:0]                   frame_start = 3'h0;
   logic [2:0]                   frame_end = 3'h0;
   stp_gate_pkg::frame_req_t     req = '0;
   stp_gate_pkg::frame_req_t     r;
   logic [2:0]                   flush_ack = 3'h0;
   stp_gate_pkg::decision_t      result;
   logic [2:0]                   flush_req;
   logic                         host_valid;
   logic [1:0]                   host_port;
   logic [7:0]                   host_tag;
   logic [2:0]                   h_tree = 3'h0;
   logic [7:0]                   h_sel = 8'h00;
   logic [31:0]                  seed = 32'h36;
   logic [31:0]                  a;
   stp_gate_pkg::stp_ctl_t [2:0] snap;
   int                           errors = 0;
   int                           comparisons = 0;
   int                           cycles = 0;
   int                           kept = 0;
   logic                         host_keep;
   logic [4:0]                   exp_q[$];
   stp_port_state_gate u_dut (.clock(clock), .reset(reset),
      .tail_tag_enable(tail_tag_enable), .port_ctl(port_ctl),
      .frame_start(frame_start), .frame_end(frame_end), .req(req),
      .flush_ack(flush_ack), .result(result), .flush_req(flush_req),
      .host_valid(host_valid), .host_port(host_port));
   host_proc_model u_host (.ctl(port_ctl), .tree(h_tree), .sel(h_sel),
      .from_port(req.port), .tail_tag(host_tag), .keep(host_keep));
   always #4 clock = ~clock;
   always @(negedge clock) begin
      if (result.valid !== 1'h0) begin
         check(exp_q.size() == 1, "unexpected result");
         if (exp_q.size() > 0) begin
            check(result === exp_q.pop_front(), "result value");
         end
         if (result.egress[2] === 1'h1 && host_keep === 1'h1) begin
            kept++;
         end
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles > 2000) begin
         errors++;
         tally_and_finish();
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [3:0] expect_dec(stp_gate_pkg::frame_req_t q,
         stp_gate_pkg::stp_ctl_t [2:0] c);
      logic [2:0] tx;
      logic [2:0] ovr;
      int         t;
      t = q.tree;
      ovr = q.static_override ? 3'h4 : 3'h0;
      for (int d = 0; d < 3; d++) tx[d] = c[d].tx_permit[t];
      if (q.port == 3) return 4'h0;
      if (q.port == 2) begin
         if (q.tail_tag[6]) return {q.lookup_mask & 3'h3 & tx, 1'h1};
         if (q.tail_tag[5]) return {q.tail_tag[2:0] & 3'h3, 1'h1};
         return {q.tail_tag[2:0] & 3'h3 & tx, 1'h1};
      end
      if (!c[q.port].rx_permit[t]) return {ovr, ~c[q.port].learn_inhibit[t]};
      return {((q.lookup_mask & (tx | 3'h4)) | ovr) & ~(3'h1 << q.port),
         ~c[q.port].learn_inhibit[t]};
   endfunction
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'h1) begin
         errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task automatic do_req(stp_gate_pkg::frame_req_t q,
         stp_gate_pkg::stp_ctl_t [2:0] c);
      logic [3:0] e;
      e = expect_dec(q, c);
      q.valid = 1'h1;
      @(posedge clock) #1 req = q;
      exp_q.push_back({1'h1, e});
      @(posedge clock) #1 req.valid = 1'h0;
      check(result === {1'h1, e}, "decision mismatch");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d kept %0d", comparisons, errors,
         kept);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1 check(result === '0 && flush_req === 3'h0 && host_valid === 1'h0,
         "reset outputs");
      reset = 1'h0;
      repeat (2) @(posedge clock);
      #1 check(host_valid === 1'h1 && host_port === 2'h2, "host");
      for (int i = 0; i < 60; i++) begin
         for (int p = 0; p < 3; p++) begin
            a = xs();
            port_ctl[p] = {a[7:0], a[7:0], ~(a[7:0] | a[15:8])};
         end
         a = xs();
         h_tree = a[4:2];
         h_sel = a[31:24];
         repeat (2) @(posedge clock);
         #1 r = {1'h0, a[1:0], a[4:2], a[7:5], a[8], a[23:16]};
         if (a[1:0] == 2'h2) r.tail_tag = host_tag;
         do_req(r, port_ctl);
      end
      $display("random decisions done");
      port_ctl = {3{24'hFFFF00}};
      repeat (2) @(posedge clock);
      #1 frame_start = 3'h1;
      snap = port_ctl;
      @(posedge clock) #1 frame_start = 3'h0;
      port_ctl[0].rx_permit = 8'h00;
      r = {1'h0, 2'h0, 3'h0, 3'h2, 1'h0, 8'h00};
      repeat (2) @(posedge clock);
      do_req(r, snap);
      frame_end = 3'h1;
      @(posedge clock) #1 frame_end = 3'h0;
      repeat (2) @(posedge clock);
      do_req(r, port_ctl);
      $display("frame snapshot done");
      flush_ack = 3'h7;
      @(posedge clock) #1 flush_ack = 3'h0;
      check(flush_req === 3'h0, "flush idle");
      port_ctl[1].learn_inhibit = 8'h10;
      repeat (3) @(posedge clock);
      #1 check(flush_req === 3'h2, "flush raise");
      repeat (3) @(posedge clock);
      #1 check(flush_req === 3'h2, "flush hold");
      flush_ack = 3'h2;
      @(posedge clock) #1 flush_ack = 3'h0;
      check(flush_req === 3'h0, "flush drop");
      $display("flush done");
      tail_tag_enable = 3'h3;
      repeat (2) @(posedge clock);
      #1 check(host_valid === 1'h0, "two hosts");
      $display("host select done");
      check(exp_q.size() == 0, "result missing");
      tally_and_finish();
   end
endmodule // tb_stp_port_state_gate
